// [src/adsc_pkg.sv]
// Package of register offsets, fields, reset values and types for the converter control block.
package adsc_pkg;
   localparam logic [11:0] ADDR_RESULT_HIGH  = 12'h000;
   localparam logic [11:0] ADDR_RESULT_LOW   = 12'h004;
   localparam logic [11:0] ADDR_CONTROL_0    = 12'h008;
   localparam logic [11:0] ADDR_CONTROL_1    = 12'h00C;
   localparam logic [11:0] ADDR_PIN_FUNC     = 12'h010;
   localparam logic [11:0] ADDR_INT_STATUS   = 12'h014;
   localparam logic [11:0] ADDR_INT_ENABLE   = 12'h018;
   localparam logic [11:0] ADDR_INT_CLEAR    = 12'h01C;
   localparam logic [11:0] ADDR_SAMPLE_DATA  = 12'h020;
   localparam int          BIT_START         = 7;
   localparam int          BIT_BUSY          = 6;
   localparam int          BIT_POWER         = 5;
   localparam int          BIT_JUSTIFY       = 4;
   localparam logic [7:0]  RESET_CONTROL_0   = 8'h00;
   localparam logic [7:0]  RESET_CONTROL_1   = 8'h00;
   localparam logic [3:0]  RESET_PIN_FUNC    = 4'h0;
   localparam logic [3:0]  CHAN_SENSE        = 4'h4;
   localparam int          SAMPLE_CLOCKS     = 4;
   localparam int          CONVERT_CLOCKS    = 12;
   localparam logic [4:0]  TOTAL_CLOCKS      = 5'h10;

   typedef enum logic [1:0] {
      ADSC_IDLE   = 2'b00,
      ADSC_RESET  = 2'b01,
      ADSC_CONV   = 2'b10,
      ADSC_LATCH  = 2'b11
   } adsc_state_t;

   typedef struct packed {
      logic [3:0] ext_select;
      logic       ext_connect;
      logic       bandgap_on;
      logic       current_sense_on;
      logic       ground_on;
      logic       ref_supply;
      logic       power_on;
      logic       core_reset;
      logic       sample;
   } adsc_analog_t;
endpackage : adsc_pkg

// [src/adsc_ctrl.sv]
// Converter control, result formatting and APB register file.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps

// Summary of operation
// - Justify bit 0 puts result 11..4 high, 3..0 in the low byte's top nibble; 1 puts 11..8 and 7..0.
// - Result bits carrying no conversion data read as zero.
// - Channel codes 0000-0011 pick pins zero to three, 0100 sense, others float.
// - Source 000 pins, 001 bandgap, 010 current sense, 011/100 ground, 101-111 like 000.
// - Selecting an internal source disconnects the external channel input.
// - Reference code 00 external pin, 01 supply, 10 and 11 like 00.
// - Clock code n divides the system clock by two to the n.
// - Start bit rising holds the converter in reset and clears busy.
// - Start bit falling releases reset, begins conversion, sets busy.
// - Busy reads 1 during a conversion and 0 otherwise.
// - Completion clears busy, sets interrupt flag; output only when enabled.
// - Power enable bit powers the converter on when 1, off when 0.
// - Pins chosen as analog inputs lose digital function and pull-up.
// - A conversion takes 4 sampling plus 12 converting clocks, 16 in total.
// - Result latches half a converter clock after the end; restart there corrupts it.
module adsc_ctrl #(
   parameter int RESULT_WIDTH = 12,
   parameter int PIN_COUNT    = 4
) (
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire logic [RESULT_WIDTH-1:0]  core_data,
   output adsc_pkg::adsc_analog_t        analog_ctrl,
   output logic      [PIN_COUNT-1:0]     pin_digital_disable,
   output logic      [PIN_COUNT-1:0]     pin_pullup_disable,
   output logic                          irq
);

   typedef struct packed {
      adsc_pkg::adsc_state_t    state;
      logic [7:0]               control_0;
      logic [7:0]               control_1;
      logic [PIN_COUNT-1:0]     pin_func;
      logic [6:0]               div_count;
      logic                     conv_tick;
      logic [4:0]               clocks_left;
      logic [RESULT_WIDTH-1:0]  result;
      logic                     int_status;
      logic                     int_enable;
      logic [31:0]              rdata;
      logic [7:0]               busy_cycles;
   } adsc_regs_t;

   adsc_regs_t  r;
   adsc_regs_t  next_r;
   logic        wr_access;
   logic        rd_access;
   logic        mapped;
   logic        start_rise;
   logic        start_fall;
   logic [7:0]  new_control_0;
   logic [7:0]  result_high;
   logic [7:0]  result_low;
   logic [2:0]  source;

   // Division of 2**code reduced to a terminal count for the free-running divider.
   function automatic logic [6:0] div_limit(input logic [2:0] code);
      div_limit = 7'((8'h01 << code) - 8'h01);
   endfunction : div_limit

   function automatic logic [7:0] low_byte(input logic [11:0] d, input logic justify);
      low_byte = justify ? d[7:0] : {d[3:0], 4'h0};
   endfunction : low_byte

   function automatic logic [7:0] high_byte(input logic [11:0] d, input logic justify);
      high_byte = justify ? {4'h0, d[11:8]} : d[11:4];
   endfunction : high_byte

   assign pready    = 1'b1;
   assign wr_access = psel && penable && pwrite;
   assign rd_access = psel && !penable && !pwrite;
   assign mapped    = (paddr == adsc_pkg::ADDR_RESULT_HIGH) || (paddr == adsc_pkg::ADDR_RESULT_LOW) ||
                      (paddr == adsc_pkg::ADDR_CONTROL_0) || (paddr == adsc_pkg::ADDR_CONTROL_1) ||
                      (paddr == adsc_pkg::ADDR_PIN_FUNC) || (paddr == adsc_pkg::ADDR_INT_STATUS) ||
                      (paddr == adsc_pkg::ADDR_INT_ENABLE) || (paddr == adsc_pkg::ADDR_INT_CLEAR);
   assign pslverr   = psel && penable && !mapped;
   assign prdata    = r.rdata;
   assign new_control_0 = {pwdata[7], 1'b0, pwdata[5:0]};
   assign start_rise = wr_access && (paddr == adsc_pkg::ADDR_CONTROL_0) &&
                       !r.control_0[adsc_pkg::BIT_START] && pwdata[adsc_pkg::BIT_START];
   assign start_fall = wr_access && (paddr == adsc_pkg::ADDR_CONTROL_0) &&
                       r.control_0[adsc_pkg::BIT_START] && !pwdata[adsc_pkg::BIT_START];
   assign result_high = high_byte(r.result, r.control_0[adsc_pkg::BIT_JUSTIFY]);
   assign result_low  = low_byte(r.result, r.control_0[adsc_pkg::BIT_JUSTIFY]);
   assign source      = r.control_1[7:5];

   always_comb begin
      next_r = r;
      // Read data is held until the next read setup, so the master can take it in the access phase.
      // Converter clock: one tick each 2**code system clocks; code 0 ticks every clock.
      if (r.div_count >= div_limit(r.control_1[2:0])) begin
         next_r.div_count = 7'h00;
         next_r.conv_tick = 1'b1;
      end else begin
         next_r.div_count = 7'(r.div_count + 7'h01);
         next_r.conv_tick = 1'b0;
      end
      // Cycles spent busy, saturating, so that the length of a conversion can be checked.
      if (!r.control_0[adsc_pkg::BIT_BUSY]) begin
         next_r.busy_cycles = 8'h00;
      end else if (r.busy_cycles != 8'hFF) begin
         next_r.busy_cycles = 8'(r.busy_cycles + 8'h01);
      end
      if (rd_access) begin
         case (paddr)
            adsc_pkg::ADDR_RESULT_HIGH: next_r.rdata = {24'h00_0000, result_high};
            adsc_pkg::ADDR_RESULT_LOW:  next_r.rdata = {24'h00_0000, result_low};
            adsc_pkg::ADDR_CONTROL_0:   next_r.rdata = {24'h00_0000, r.control_0};
            adsc_pkg::ADDR_CONTROL_1:   next_r.rdata = {24'h00_0000, r.control_1};
            adsc_pkg::ADDR_PIN_FUNC:    next_r.rdata = {{(32-PIN_COUNT){1'b0}}, r.pin_func};
            adsc_pkg::ADDR_INT_STATUS:  next_r.rdata = {31'h0000_0000, r.int_status};
            adsc_pkg::ADDR_INT_ENABLE:  next_r.rdata = {31'h0000_0000, r.int_enable};
            default:                    next_r.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_access) begin
         case (paddr)
            adsc_pkg::ADDR_CONTROL_0: begin
               next_r.control_0 = {new_control_0[7], r.control_0[adsc_pkg::BIT_BUSY], new_control_0[5:0]};
            end
            adsc_pkg::ADDR_CONTROL_1:  next_r.control_1  = pwdata[7:0];
            adsc_pkg::ADDR_PIN_FUNC:   next_r.pin_func   = pwdata[PIN_COUNT-1:0];
            adsc_pkg::ADDR_INT_ENABLE: next_r.int_enable = pwdata[0];
            adsc_pkg::ADDR_INT_CLEAR: begin
               if (pwdata[0]) begin
                  next_r.int_status = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      case (r.state)
         adsc_pkg::ADSC_IDLE, adsc_pkg::ADSC_CONV, adsc_pkg::ADSC_LATCH: begin
            if (r.state == adsc_pkg::ADSC_CONV && r.conv_tick) begin
               if (r.clocks_left == 5'h01) begin
                  next_r.state = adsc_pkg::ADSC_LATCH;
               end
               next_r.clocks_left = 5'(r.clocks_left - 5'h01);
            end
            // Result latches half a converter clock after the end of conversion.
            if (r.state == adsc_pkg::ADSC_LATCH && r.div_count == (div_limit(r.control_1[2:0]) >> 1)) begin
               next_r.result = core_data;
               next_r.control_0[adsc_pkg::BIT_BUSY] = 1'b0;
               next_r.int_status = 1'b1;
               next_r.state = adsc_pkg::ADSC_IDLE;
            end
         end
         adsc_pkg::ADSC_RESET: begin
         end
         default: next_r.state = adsc_pkg::ADSC_IDLE;
      endcase
      if (start_rise) begin
         next_r.state = adsc_pkg::ADSC_RESET;
         next_r.control_0[adsc_pkg::BIT_BUSY] = 1'b0;
      end else if (start_fall && r.state == adsc_pkg::ADSC_RESET) begin
         next_r.state = adsc_pkg::ADSC_CONV;
         next_r.clocks_left = adsc_pkg::TOTAL_CLOCKS;
         // Restarting the divider realigns the converter clocks, but a tick already due at the falling write still counts in the first cycle.
         next_r.div_count   = 7'h00;
         next_r.control_0[adsc_pkg::BIT_BUSY] = 1'b1;
      end
      // Power off stops any conversion; the held result stays readable.
      if (!next_r.control_0[adsc_pkg::BIT_POWER]) begin
         if (next_r.state != adsc_pkg::ADSC_RESET) begin
            next_r.state = adsc_pkg::ADSC_IDLE;
         end
         next_r.control_0[adsc_pkg::BIT_BUSY] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r.state       <= adsc_pkg::ADSC_IDLE;
         r.control_0   <= adsc_pkg::RESET_CONTROL_0;
         r.control_1   <= adsc_pkg::RESET_CONTROL_1;
         r.pin_func    <= PIN_COUNT'(adsc_pkg::RESET_PIN_FUNC);
         r.div_count   <= 7'h00;
         r.conv_tick   <= 1'b0;
         r.clocks_left <= 5'h00;
         r.result      <= '0;
         r.int_status  <= 1'b0;
         r.int_enable  <= 1'b0;
         r.rdata       <= 32'h0000_0000;
         r.busy_cycles <= 8'h00;
      end else begin
         r <= next_r;
      end
   end

   always_comb begin
      analog_ctrl = '0;
      analog_ctrl.ext_select = r.control_0[3:0];
      // Internal sources and ground take the input path away from the pins.
      analog_ctrl.bandgap_on       = (source == 3'h1);
      analog_ctrl.current_sense_on = (source == 3'h2);
      analog_ctrl.ground_on        = (source == 3'h3) || (source == 3'h4);
      analog_ctrl.ext_connect      = !(source inside {3'h1, 3'h2, 3'h3, 3'h4}) &&
                                     (r.control_0[3:0] <= adsc_pkg::CHAN_SENSE);
      analog_ctrl.ref_supply       = (r.control_1[4:3] == 2'h1);
      analog_ctrl.power_on         = r.control_0[adsc_pkg::BIT_POWER];
      analog_ctrl.core_reset       = (r.state == adsc_pkg::ADSC_RESET) || !r.control_0[adsc_pkg::BIT_POWER];
      analog_ctrl.sample           = (r.state == adsc_pkg::ADSC_CONV) &&
                                     (r.clocks_left > 5'(adsc_pkg::CONVERT_CLOCKS));
   end

   assign pin_digital_disable = r.pin_func;
   assign pin_pullup_disable  = r.pin_func;
   assign irq = r.int_status && r.int_enable;

   property p_rise_resets;
      @(posedge pclk) disable iff (!presetn) start_rise |=> (r.state == adsc_pkg::ADSC_RESET) && !r.control_0[6];
   endproperty
   a_rise_resets: assert property (p_rise_resets) else $error("start rise did not reset");

   property p_fall_starts;
      @(posedge pclk) disable iff (!presetn)
         (start_fall && r.state == adsc_pkg::ADSC_RESET && next_r.control_0[5]) |=> r.control_0[6] && r.clocks_left == 5'h10;
   endproperty
   a_fall_starts: assert property (p_fall_starts) else $error("start fall did not begin conversion");

   property p_hold_in_reset;
      @(posedge pclk) disable iff (!presetn) (r.state == adsc_pkg::ADSC_RESET) |-> !r.control_0[6] && analog_ctrl.core_reset;
   endproperty
   a_hold_in_reset: assert property (p_hold_in_reset) else $error("busy during reset");

   property p_busy_state;
      @(posedge pclk) disable iff (!presetn) r.control_0[6] |-> (r.state inside {adsc_pkg::ADSC_CONV, adsc_pkg::ADSC_LATCH});
   endproperty
   a_busy_state: assert property (p_busy_state) else $error("busy without conversion");

   property p_done_flags;
      @(posedge pclk) disable iff (!presetn) $fell(r.control_0[6]) && r.control_0[5] && $past(r.state) == adsc_pkg::ADSC_LATCH |-> r.int_status;
   endproperty
   a_done_flags: assert property (p_done_flags) else $error("completion did not set interrupt flag");

   property p_irq_gate;
      @(posedge pclk) disable iff (!presetn) irq == (r.int_status && r.int_enable);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

   property p_justify;
      @(posedge pclk) disable iff (!presetn) r.control_0[4] |-> result_high[7:4] == 4'h0 && result_low == r.result[7:0];
   endproperty
   a_justify: assert property (p_justify) else $error("right justify layout wrong");

   property p_left;
      @(posedge pclk) disable iff (!presetn) !r.control_0[4] |-> result_low[3:0] == 4'h0 && result_high == r.result[11:4];
   endproperty
   a_left: assert property (p_left) else $error("left justify layout wrong");

   property p_isolate;
      @(posedge pclk) disable iff (!presetn) (source == 3'h1 || source == 3'h2) |-> !analog_ctrl.ext_connect;
   endproperty
   a_isolate: assert property (p_isolate) else $error("external input not isolated");

   property p_result_stable;
      @(posedge pclk) disable iff (!presetn) (r.state != adsc_pkg::ADSC_LATCH) |=> $stable(r.result);
   endproperty
   a_result_stable: assert property (p_result_stable) else $error("result changed outside latch");

   sequence s_conv_done;
      $fell(r.control_0[6]) && $past(r.state) == adsc_pkg::ADSC_LATCH && r.control_1[2:0] == 3'h0;
   endsequence

   sequence s_length_ok;
      r.busy_cycles >= 8'(adsc_pkg::TOTAL_CLOCKS) && r.busy_cycles <= 8'h12;
   endsequence

   property p_length;
      @(posedge pclk) disable iff (!presetn) s_conv_done |-> s_length_ok;
   endproperty
   a_length: assert property (p_length) else $error("conversion length wrong");

   property p_ref_decode;
      @(posedge pclk) disable iff (!presetn) (r.control_1[4:3] != 2'h1) |-> !analog_ctrl.ref_supply;
   endproperty
   a_ref_decode: assert property (p_ref_decode) else $error("reference decode wrong");

   property p_float;
      @(posedge pclk) disable iff (!presetn) (r.control_0[3:0] > adsc_pkg::CHAN_SENSE) |-> !analog_ctrl.ext_connect;
   endproperty
   a_float: assert property (p_float) else $error("unused channel code connected");

   property p_ground;
      @(posedge pclk) disable iff (!presetn) (source == 3'h3 || source == 3'h4) |->
         analog_ctrl.ground_on && !analog_ctrl.bandgap_on && !analog_ctrl.current_sense_on && !analog_ctrl.ext_connect;
   endproperty
   a_ground: assert property (p_ground) else $error("ground source decode wrong");

   property p_pins;
      @(posedge pclk) disable iff (!presetn) pin_pullup_disable == r.pin_func && pin_digital_disable == r.pin_func;
   endproperty
   a_pins: assert property (p_pins) else $error("pin function not applied");

   property p_power_off;
      @(posedge pclk) disable iff (!presetn) !r.control_0[5] |->
         !analog_ctrl.power_on && analog_ctrl.core_reset && !r.control_0[6];
   endproperty
   a_power_off: assert property (p_power_off) else $error("converter active while powered off");

   property p_tick_fast;
      @(posedge pclk) disable iff (!presetn) (r.control_1[2:0] == 3'h0) |=> r.conv_tick;
   endproperty
   a_tick_fast: assert property (p_tick_fast) else $error("undivided clock did not tick");

   property p_sample_phase;
      @(posedge pclk) disable iff (!presetn)
         (r.state == adsc_pkg::ADSC_CONV && r.clocks_left > 5'(adsc_pkg::CONVERT_CLOCKS)) |-> analog_ctrl.sample;
   endproperty
   a_sample_phase: assert property (p_sample_phase) else $error("sampling phase missing");

   property p_int_clear;
      @(posedge pclk) disable iff (!presetn)
         (wr_access && paddr == adsc_pkg::ADDR_INT_CLEAR && pwdata[0] && r.state != adsc_pkg::ADSC_LATCH) |=> !r.int_status;
   endproperty
   a_int_clear: assert property (p_int_clear) else $error("interrupt flag not cleared");

endmodule : adsc_ctrl

// [verif/adc_sequencer_control_tb_top.sv]
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module adc_sequencer_control_tb_top;
   logic                   pclk;
   logic                   presetn;
   logic                   psel;
   logic                   penable;
   logic                   pwrite;
   logic [11:0]            paddr;
   logic [31:0]            pwdata;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [11:0]            core_data;
   adsc_pkg::adsc_analog_t analog_ctrl;
   logic [3:0]             pin_digital_disable;
   logic [3:0]             pin_pullup_disable;
   logic                   irq;
   int                     fails;
   int                     samples_checked;
   logic [31:0]            rd;
   logic                   err;
   int                     n;

   adsc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_data(core_data), .analog_ctrl(analog_ctrl), .pin_digital_disable(pin_digital_disable),
      .pin_pullup_disable(pin_pullup_disable), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // The master never assumes a latency; only the bounded wait ends a missing answer.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 100);
      rd = prdata;
      err = pslverr;
      if (k >= 100) begin
         chk("pready", 32'h1, 32'h0);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write settle before callers look at the outputs.
      @(negedge pclk);
   endtask : apb

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rchk

   task automatic wait_irq(output int cnt);
      cnt = 0;
      while (irq !== 1'b1 && cnt < 3000) begin
         @(posedge pclk);
         cnt++;
      end
      if (cnt >= 3000) begin
         chk("irq timeout", 32'h1, 32'h0);
      end
   endtask : wait_irq

   task automatic t_reset_and_refuse();
      rchk("control 0 reset", adsc_pkg::ADDR_CONTROL_0, 32'h0000_0000);
      rchk("control 1 reset", adsc_pkg::ADDR_CONTROL_1, 32'h0000_0000);
      chk("irq reset", 32'h0, {31'h0, irq});
      apb(1'b0, 12'h0F0, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h0000_0040);
      rchk("busy not writable", adsc_pkg::ADDR_CONTROL_0, 32'h0000_0000);
   endtask : t_reset_and_refuse

   task automatic t_convert();
      apb(1'b1, adsc_pkg::ADDR_INT_ENABLE, 32'h1);
      core_data <= 12'hABC;
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h20);
      chk("power on", 32'h1, {31'h0, analog_ctrl.power_on});
      repeat (8) @(posedge pclk);
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'hA0);
      chk("core reset", 32'h1, {31'h0, analog_ctrl.core_reset});
      rchk("busy after rise", adsc_pkg::ADDR_CONTROL_0, 32'hA0);
      repeat (40) @(posedge pclk);
      chk("no conversion while high", 32'h0, {31'h0, irq});
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h20);
      rchk("busy after fall", adsc_pkg::ADDR_CONTROL_0, 32'h60);
      wait_irq(n);
      rchk("busy at end", adsc_pkg::ADDR_CONTROL_0, 32'h20);
      rchk("int status", adsc_pkg::ADDR_INT_STATUS, 32'h1);
      rchk("high left", adsc_pkg::ADDR_RESULT_HIGH, 32'hAB);
      rchk("low left", adsc_pkg::ADDR_RESULT_LOW, 32'hC0);
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h30);
      rchk("high right", adsc_pkg::ADDR_RESULT_HIGH, 32'h0A);
      rchk("low right", adsc_pkg::ADDR_RESULT_LOW, 32'hBC);
      core_data <= 12'h123;
      rchk("result holds", adsc_pkg::ADDR_RESULT_HIGH, 32'h0A);
      apb(1'b1, adsc_pkg::ADDR_INT_CLEAR, 32'h1);
      chk("irq cleared", 32'h0, {31'h0, irq});
      apb(1'b1, adsc_pkg::ADDR_INT_ENABLE, 32'h0);
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'hB0);
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h30);
      repeat (40) @(posedge pclk);
      chk("irq masked", 32'h0, {31'h0, irq});
      rchk("status masked", adsc_pkg::ADDR_INT_STATUS, 32'h1);
      rchk("new low", adsc_pkg::ADDR_RESULT_LOW, 32'h23);
      apb(1'b1, adsc_pkg::ADDR_INT_CLEAR, 32'h1);
      apb(1'b1, adsc_pkg::ADDR_INT_ENABLE, 32'h1);
   endtask : t_convert

   // Time from the releasing write to the interrupt scales with the divider.
   task automatic t_divider();
      for (int d = 0; d < 8; d++) begin
         apb(1'b1, adsc_pkg::ADDR_CONTROL_1, 32'(d));
         apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'hA0);
         apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h20);
         wait_irq(n);
         chk("conversion length", 32'h1, {31'h0, (n >= (16 << d)) && (n <= (16 << d) + (1 << d) + 4)});
         apb(1'b1, adsc_pkg::ADDR_INT_CLEAR, 32'h1);
      end
   endtask : t_divider

   task automatic t_select();
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h20 | 32'(c));
         chk("channel", 32'(c), {28'h0, analog_ctrl.ext_select});
         chk("channel path", 32'(c <= 4), {31'h0, analog_ctrl.ext_connect});
      end
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h20);
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, adsc_pkg::ADDR_CONTROL_1, 32'(s << 5) | 32'((s & 3) << 3));
         chk("bandgap", 32'(s == 1), {31'h0, analog_ctrl.bandgap_on});
         chk("current sense", 32'(s == 2), {31'h0, analog_ctrl.current_sense_on});
         chk("ground", 32'(s == 3 || s == 4), {31'h0, analog_ctrl.ground_on});
         if (s != 3 && s != 4) begin
            chk("external path", 32'(s != 1 && s != 2), {31'h0, analog_ctrl.ext_connect});
         end
         chk("reference", 32'((s & 3) == 1), {31'h0, analog_ctrl.ref_supply});
      end
      apb(1'b1, adsc_pkg::ADDR_PIN_FUNC, 32'h5);
      chk("digital off", 32'h5, {28'h0, pin_digital_disable});
      chk("pull-up off", 32'h5, {28'h0, pin_pullup_disable});
      apb(1'b1, adsc_pkg::ADDR_CONTROL_0, 32'h00);
      chk("power off", 32'h0, {31'h0, analog_ctrl.power_on});
   endtask : t_select

   task automatic conclude();
      if (fails == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude

   initial begin
      #(50 * 20000);
      fails++;
      conclude();
   end

   initial begin
      fails = 0;
      samples_checked = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      core_data = 12'h000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_and_refuse();
      t_convert();
      t_divider();
      t_select();
      conclude();
   end
endmodule : adc_sequencer_control_tb_top
